/* hw/rsc_map.svh */
// offsets, field positions, reset values and timing for the reset and strap block
`ifndef RSC_MAP_SVH
`define RSC_MAP_SVH
// clock and timing
`define RSC_CLK_NS 10
`define RSC_CLK_KHZ 100000
`define RSC_RST_PROC_NS 160
`define RSC_RST_PROC_CYC ((`RSC_RST_PROC_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS)
`define RSC_SMB_SLOW_KHZ 100
`define RSC_SMB_FAST_KHZ 400
`define RSC_SMB_SLOW_CYC (`RSC_CLK_KHZ / `RSC_SMB_SLOW_KHZ)
`define RSC_SMB_FAST_CYC (`RSC_CLK_KHZ / `RSC_SMB_FAST_KHZ)
// fixed smbus addresses and pin-driven bits
`define RSC_SLV_ADDR_DEF 7'h77
`define RSC_EE_ADDR_DEF 7'h50
// address bits that the address pins replace
`define RSC_SLV_PIN_MASK 7'h2E
`define RSC_EE_PIN_MASK 7'h1E
// switch mode codes
`define RSC_MODE_NORMAL 3'h0
`define RSC_MODE_EEPROM 3'h1
// register offsets
`define RSC_OFF_SW_CTRL 8'h00
`define RSC_OFF_ALTSEL 8'h04
`define RSC_OFF_US_LSTS 8'h08
`define RSC_OFF_DSA_LSTS 8'h0C
`define RSC_OFF_DSB_LSTS 8'h10
`define RSC_OFF_STATUS 8'h14
`define RSC_OFF_PORTCTL 8'h18
// field positions
`define RSC_SW_CTRL_HALT 0
`define RSC_LSTS_SCLK 12
`define RSC_PCTL_RSTA 0
`define RSC_PCTL_RSTB 1
`define RSC_PCTL_EVT 2
`define RSC_ALT_MASK 8'h9F
// gpio pin numbers with alternate functions
`define RSC_PIN_RSTA 0
`define RSC_PIN_RSTB 1
`define RSC_PIN_IRQ0 2
`define RSC_PIN_EVT 7
// reset values
`define RSC_ALTSEL_RST 8'h00
`define RSC_PCTL_RST 3'h0
`endif

/* hw/rsc_pkg.sv */
// types shared by the reset and strap block
package rsc_pkg;
  // reset sequencer states
  typedef enum logic [1:0] {RSC_ST_PROC, RSC_ST_HALT, RSC_ST_RUN} rsc_state_t;
  // captured strap levels
  typedef struct packed {
    logic [2:0] switch_mode_strap;
    logic dsClk;
    logic usClk;
    logic slow;
    logic hold;
    logic slvPresent;
    logic [3:0] slvPins;
    logic eePresent;
    logic [3:0] eePins;
  } rsc_strap_t;
  // register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } rsc_req_t;
endpackage : rsc_pkg

/* hw/rsc_reset_strap_config.sv */
// reset sequencing, strap capture and gpio alternate functions of the switch
// Behaviour
// [RL1] slave smbus address 0x77 without pins
// [RL2] eeprom address 0x50 without pins
// [RL3] gpio 0 drives downstream port A reset
// [RL4] gpio 1 drives downstream port B reset
// [RL5] gpio 2..4 take expander interrupts 0..2
// [RL6] gpio 7 drives event output
// [RL7] downstream strap loads downstream slot clock bits
// [RL8] software writes override downstream slot clock
// [RL9] upstream strap loads upstream bit, writable
// [RL10] master smbus 100 kHz slow, else 400
// [RL11] smbus speed not changeable by software
// [RL12] fundamental reset resets all, starts link reset
// [RL13] hold input keeps device in reset, smbus alive
// [RL14] clearing halt bit releases held reset
// [RL15] mode 0 normal, 1 eeprom, rest reserved
// [RL16] board keeps straps steady after reset
// [RL17] straps captured once after reset release
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`include "rsc_map.svh"
module rsc_reset_strap_config (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clkEn,
  // strap pins
  input wire logic [2:0] switchModeStrap,
  input wire logic downstreamCommonClockStrap,
  input wire logic upstreamCommonClockStrap,
  input wire logic masterSmbusSlowStrap,
  input wire logic resetHoldInput,
  input wire logic slaveAddrPinsPresent,
  input wire logic [3:0] slaveSmbusAddrPins,
  input wire logic eepromAddrPinsPresent,
  input wire logic [3:0] eepromAddrPins,
  // gpio pads
  input wire logic [10:0] gpioIn,
  output logic [10:0] gpioOut,
  output logic [10:0] gpioOe,
  // register bus
  input rsc_pkg::rsc_req_t regReq,
  output logic [31:0] regRdata,
  // derived configuration
  output logic [6:0] slaveSmbusAddr,
  output logic [6:0] eepromAddr,
  output logic smbSlowMode,
  output logic [9:0] smbPeriodCycles,
  output logic smbusEnable,
  output logic eepromInitEnable,
  output logic modeReserved,
  output logic upstreamSlotClock,
  output logic [1:0] downstreamSlotClock,
  output logic [2:0] expanderIrq,
  output logic coreInReset
);
  import rsc_pkg::*;

  // merge address pins into a fixed base; pin bits selected by mask
  function automatic logic [6:0] mergeAddr(input logic [6:0] base, input logic [6:0] pinBits,
                                           input logic [6:0] mask);
    mergeAddr = (base & ~mask) | (pinBits & mask);
  endfunction : mergeAddr

  logic rstMeta_b; // first synchroniser stage
  logic rstSync_b; // released reset used everywhere
  rsc_state_t state; // sequencer state
  logic [7:0] procCnt; // reset procedure counter
  logic strapsValid; // straps have been captured
  rsc_strap_t cap; // captured straps
  logic haltBit; // halt bit of switch control register
  logic [7:0] altSel; // alternate function select per pin
  logic [2:0] portCtl; // software port resets and event
  logic inReset; // device not yet running
  logic [10:0] next_gpioOut; // next pad levels
  logic [10:0] next_gpioOe; // next pad enables
  logic wrHit; // helper: write strobe
  logic [31:0] next_rdata; // read mux

  assign inReset = (state != RSC_ST_RUN);
  assign wrHit = regReq.wr;

  // reset release through two flip-flops
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_b <= 1'b0;
      rstSync_b <= 1'b0;
    end else if (clkEn) begin
      rstMeta_b <= 1'b1;
      rstSync_b <= rstMeta_b;
    end
  end

  // strap capture on the first enabled edge after release
  always_ff @(posedge sys_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      strapsValid <= 1'b0;
      cap <= '0;
    end else if (clkEn && !strapsValid) begin // see [RL17]
      strapsValid <= 1'b1;
      cap.switch_mode_strap <= switchModeStrap; // see [RL16]
      cap.dsClk <= downstreamCommonClockStrap;
      cap.usClk <= upstreamCommonClockStrap;
      cap.slow <= masterSmbusSlowStrap;
      cap.hold <= resetHoldInput;
      cap.slvPresent <= slaveAddrPinsPresent;
      cap.slvPins <= slaveSmbusAddrPins;
      cap.eePresent <= eepromAddrPinsPresent;
      cap.eePins <= eepromAddrPins;
    end
  end

  // reset sequencer: procedure, optional hold, run
  always_ff @(posedge sys_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      state <= RSC_ST_PROC; // see [RL12]
      procCnt <= 8'h00;
    end else if (clkEn) begin
      unique case (state)
        RSC_ST_PROC: begin
          procCnt <= procCnt + 8'h01;
          // procedure done: hold or run
          if (procCnt == 8'(`RSC_RST_PROC_CYC - 1)) begin
            state <= cap.hold ? RSC_ST_HALT : RSC_ST_RUN; // see [RL13]
          end
        end
        RSC_ST_HALT: begin
          // leave once software clears halt
          if (!haltBit) begin
            state <= RSC_ST_RUN; // see [RL14]
          end
        end
        RSC_ST_RUN: begin
          state <= RSC_ST_RUN;
        end
      endcase
    end
  end

  // halt bit: loaded from hold strap, software may only clear it
  always_ff @(posedge sys_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      haltBit <= 1'b0;
    end else if (clkEn) begin
      if (!strapsValid) begin
        haltBit <= resetHoldInput; // see [RL13]
      end else if (wrHit && regReq.addr == `RSC_OFF_SW_CTRL) begin
        haltBit <= haltBit & regReq.wdata[`RSC_SW_CTRL_HALT]; // see [RL14]
      end
    end
  end

  // slot clock bits: strap initial value, software override
  always_ff @(posedge sys_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      upstreamSlotClock <= 1'b0;
      downstreamSlotClock <= 2'h0;
    end else if (clkEn) begin
      if (!strapsValid) begin
        downstreamSlotClock <= {2{downstreamCommonClockStrap}}; // see [RL7]
        upstreamSlotClock <= upstreamCommonClockStrap; // see [RL9]
      end else if (wrHit) begin
        // override per port
        if (regReq.addr == `RSC_OFF_US_LSTS) begin
          upstreamSlotClock <= regReq.wdata[`RSC_LSTS_SCLK]; // see [RL9]
        end
        if (regReq.addr == `RSC_OFF_DSA_LSTS) begin
          downstreamSlotClock[0] <= regReq.wdata[`RSC_LSTS_SCLK]; // see [RL8]
        end
        if (regReq.addr == `RSC_OFF_DSB_LSTS) begin
          downstreamSlotClock[1] <= regReq.wdata[`RSC_LSTS_SCLK]; // see [RL8]
        end
      end
    end
  end

  // alternate function select and port control registers
  always_ff @(posedge sys_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      altSel <= `RSC_ALTSEL_RST;
      portCtl <= `RSC_PCTL_RST;
    end else if (clkEn && wrHit) begin
      if (regReq.addr == `RSC_OFF_ALTSEL) begin
        altSel <= regReq.wdata[7:0] & `RSC_ALT_MASK;
      end
      if (regReq.addr == `RSC_OFF_PORTCTL) begin
        portCtl <= regReq.wdata[2:0];
      end
    end
  end

  // derived smbus and mode configuration, fixed once straps are in
  always_ff @(posedge sys_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      slaveSmbusAddr <= `RSC_SLV_ADDR_DEF;
      eepromAddr <= `RSC_EE_ADDR_DEF;
      smbSlowMode <= 1'b0;
      smbPeriodCycles <= 10'(`RSC_SMB_FAST_CYC);
      smbusEnable <= 1'b0;
      eepromInitEnable <= 1'b0;
      modeReserved <= 1'b0;
    end else if (clkEn) begin
      // address pins replace bits 5,3:1 and 4:1
      slaveSmbusAddr <= cap.slvPresent ? mergeAddr(`RSC_SLV_ADDR_DEF,
        {1'b0, cap.slvPins[3], 1'b0, cap.slvPins[2:0], 1'b0}, `RSC_SLV_PIN_MASK)
        : `RSC_SLV_ADDR_DEF; // see [RL1]
      eepromAddr <= cap.eePresent ? mergeAddr(`RSC_EE_ADDR_DEF,
        {2'h0, cap.eePins, 1'b0}, `RSC_EE_PIN_MASK) : `RSC_EE_ADDR_DEF; // see [RL2]
      // speed from strap only, no register path
      smbSlowMode <= cap.slow; // see [RL11]
      smbPeriodCycles <= cap.slow ? 10'(`RSC_SMB_SLOW_CYC)
                                  : 10'(`RSC_SMB_FAST_CYC); // see [RL10]
      smbusEnable <= strapsValid; // see [RL13]
      eepromInitEnable <= strapsValid && (cap.switch_mode_strap == `RSC_MODE_EEPROM); // see [RL15]
      modeReserved <= strapsValid && (cap.switch_mode_strap != `RSC_MODE_NORMAL)
                      && (cap.switch_mode_strap != `RSC_MODE_EEPROM); // see [RL15]
    end
  end

  // pad drive for alternate outputs
  always_comb begin
    next_gpioOut = 11'h000;
    next_gpioOe = 11'h000;
    // downstream resets are active low
    if (altSel[`RSC_PIN_RSTA]) begin
      next_gpioOe[`RSC_PIN_RSTA] = 1'b1;
      next_gpioOut[`RSC_PIN_RSTA] = !(inReset || portCtl[`RSC_PCTL_RSTA]); // see [RL3]
    end
    if (altSel[`RSC_PIN_RSTB]) begin
      next_gpioOe[`RSC_PIN_RSTB] = 1'b1;
      next_gpioOut[`RSC_PIN_RSTB] = !(inReset || portCtl[`RSC_PCTL_RSTB]); // see [RL4]
    end
    // event output
    if (altSel[`RSC_PIN_EVT]) begin
      next_gpioOe[`RSC_PIN_EVT] = 1'b1;
      next_gpioOut[`RSC_PIN_EVT] = portCtl[`RSC_PCTL_EVT]; // see [RL6]
    end
  end

  // registered pads, expander interrupts and core reset
  always_ff @(posedge sys_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      gpioOut <= 11'h000;
      gpioOe <= 11'h000;
      expanderIrq <= 3'h0;
      coreInReset <= 1'b1; // see [RL12]
    end else if (clkEn) begin
      gpioOut <= next_gpioOut;
      gpioOe <= next_gpioOe;
      // active-low interrupts on pins 2..4
      expanderIrq <= altSel[`RSC_PIN_IRQ0 +: 3] & ~gpioIn[`RSC_PIN_IRQ0 +: 3]; // see [RL5]
      coreInReset <= inReset;
    end
  end

  // read mux, unmapped reads give zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (regReq.addr)
      `RSC_OFF_SW_CTRL: next_rdata[`RSC_SW_CTRL_HALT] = haltBit;
      `RSC_OFF_ALTSEL: next_rdata[7:0] = altSel;
      `RSC_OFF_US_LSTS: next_rdata[`RSC_LSTS_SCLK] = upstreamSlotClock;
      `RSC_OFF_DSA_LSTS: next_rdata[`RSC_LSTS_SCLK] = downstreamSlotClock[0];
      `RSC_OFF_DSB_LSTS: next_rdata[`RSC_LSTS_SCLK] = downstreamSlotClock[1];
      `RSC_OFF_STATUS: next_rdata[15:0] = {1'b0, expanderIrq, 2'(state), inReset,
        cap.hold, cap.usClk, cap.dsClk, cap.slow, eepromInitEnable, modeReserved,
        cap.switch_mode_strap};
      `RSC_OFF_PORTCTL: next_rdata[2:0] = portCtl;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // read data one cycle after the strobe
  always_ff @(posedge sys_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      regRdata <= 32'h0000_0000;
    end else if (clkEn) begin
      regRdata <= regReq.rd ? next_rdata : 32'h0000_0000;
    end
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstSync_b || !clkEn);

  sequence s_procEnd;
    state == RSC_ST_PROC && procCnt == 8'(`RSC_RST_PROC_CYC - 1);
  endsequence
  sequence s_haltClear;
    state == RSC_ST_HALT && wrHit && regReq.addr == `RSC_OFF_SW_CTRL
      && !regReq.wdata[`RSC_SW_CTRL_HALT];
  endsequence

  property p_slvAddr;
    strapsValid && !cap.slvPresent |=> slaveSmbusAddr == `RSC_SLV_ADDR_DEF;
  endproperty
  a_slvAddr: assert property (p_slvAddr) else $error("slave address not 0x77"); // see [RL1]
  property p_eeAddr;
    strapsValid && !cap.eePresent |=> eepromAddr == `RSC_EE_ADDR_DEF;
  endproperty
  a_eeAddr: assert property (p_eeAddr) else $error("eeprom address not 0x50"); // see [RL2]
  property p_rstA;
    altSel[`RSC_PIN_RSTA] && inReset |=> gpioOe[0] && !gpioOut[0];
  endproperty
  a_rstA: assert property (p_rstA) else $error("port A reset not driven"); // see [RL3]
  property p_rstB;
    altSel[`RSC_PIN_RSTB] && !inReset && !portCtl[1] |=> gpioOe[1] && gpioOut[1];
  endproperty
  a_rstB: assert property (p_rstB) else $error("port B reset not released"); // see [RL4]
  property p_irq;
    altSel[3] && !gpioIn[3] |=> expanderIrq[1];
  endproperty
  a_irq: assert property (p_irq) else $error("expander irq 1 missed"); // see [RL5]
  property p_evt;
    altSel[`RSC_PIN_EVT] |=> gpioOut[7] == $past(portCtl[2]);
  endproperty
  a_evt: assert property (p_evt) else $error("event output wrong"); // see [RL6]
  property p_dsClk;
    $rose(strapsValid) |-> downstreamSlotClock == {2{cap.dsClk}} && upstreamSlotClock == cap.usClk;
  endproperty
  a_dsClk: assert property (p_dsClk) else $error("slot clock not from strap"); // see [RL7]
  property p_dsOvr;
    strapsValid && wrHit && regReq.addr == `RSC_OFF_DSA_LSTS
      |=> downstreamSlotClock[0] == $past(regReq.wdata[`RSC_LSTS_SCLK]);
  endproperty
  a_dsOvr: assert property (p_dsOvr) else $error("slot clock override lost"); // see [RL8]
  property p_speed;
    strapsValid ##1 1'b1 |-> smbSlowMode == cap.slow && smbPeriodCycles ==
      (cap.slow ? 10'(`RSC_SMB_SLOW_CYC) : 10'(`RSC_SMB_FAST_CYC));
  endproperty
  a_speed: assert property (p_speed) else $error("smbus speed mismatch"); // see [RL10]
  property p_hold;
    s_procEnd ##0 cap.hold |=> state == RSC_ST_HALT && smbusEnable [*2];
  endproperty
  a_hold: assert property (p_hold) else $error("hold not entered"); // see [RL13]
  property p_release;
    s_haltClear |=> ##1 state == RSC_ST_RUN ##1 !coreInReset;
  endproperty
  a_release: assert property (p_release) else $error("held reset not left"); // see [RL14]
  property p_mode;
    strapsValid ##1 1'b1 |-> modeReserved == (cap.switch_mode_strap > `RSC_MODE_EEPROM);
  endproperty
  a_mode: assert property (p_mode) else $error("mode decode wrong"); // see [RL15]
endmodule : rsc_reset_strap_config

/* tb/rsc_board_model.sv */
// board strap resistors, expander interrupt lines and pad resolution
module rsc_board_model (
  // wanted strap levels and expander lines
  input rsc_pkg::rsc_strap_t strapSet,
  input wire logic [2:0] irqLow,
  // switch pads
  input wire logic [10:0] gpioOut,
  input wire logic [10:0] gpioOe,
  output logic [10:0] gpioIn,
  // strap pins
  output logic [2:0] switchModeStrap,
  output logic downstreamCommonClockStrap,
  output logic upstreamCommonClockStrap,
  output logic masterSmbusSlowStrap,
  output logic resetHoldInput,
  output logic slaveAddrPinsPresent,
  output logic [3:0] slaveSmbusAddrPins,
  output logic eepromAddrPinsPresent,
  output logic [3:0] eepromAddrPins
);
  timeunit 1ns;
  timeprecision 1ps;
  import rsc_pkg::*;
  // straps are plain levels, held as long as the bench keeps them
  always_comb begin
    switchModeStrap = strapSet.switch_mode_strap;
    downstreamCommonClockStrap = strapSet.dsClk;
    upstreamCommonClockStrap = strapSet.usClk;
    masterSmbusSlowStrap = strapSet.slow;
    resetHoldInput = strapSet.hold;
    slaveAddrPinsPresent = strapSet.slvPresent;
    slaveSmbusAddrPins = strapSet.slvPins;
    eepromAddrPinsPresent = strapSet.eePresent;
    eepromAddrPins = strapSet.eePins;
  end
  // pad level: switch driver wins, else expander pulls low, else pull-up
  always_comb begin
    gpioIn = 11'h7FF;
    gpioIn[4:2] = ~irqLow;
    for (int i = 0; i < 11; i++) begin
      if (gpioOe[i]) begin
        gpioIn[i] = gpioOut[i];
      end
    end
  end
endmodule : rsc_board_model

/* tb/tb.sv */
// self-checking bench for the reset, strap and alternate pin block
`include "rsc_map.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rsc_pkg::*;
  // clock, reset and bench-driven inputs
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic clkEn = 1'b1;
  rsc_req_t regReq = '0;
  rsc_strap_t strapSet = '0;
  logic [2:0] irqLow = 3'h0;
  // strap and pad nets
  logic [2:0] switchModeStrap;
  logic downstreamCommonClockStrap, upstreamCommonClockStrap, masterSmbusSlowStrap;
  logic resetHoldInput, slaveAddrPinsPresent, eepromAddrPinsPresent;
  logic [3:0] slaveSmbusAddrPins, eepromAddrPins;
  logic [10:0] gpioIn, gpioOut, gpioOe;
  // design outputs
  logic [31:0] regRdata;
  logic [6:0] slaveSmbusAddr, eepromAddr;
  logic [9:0] smbPeriodCycles;
  logic [1:0] downstreamSlotClock;
  logic [2:0] expanderIrq;
  logic smbSlowMode, smbusEnable, eepromInitEnable, modeReserved;
  logic upstreamSlotClock, coreInReset;
  // score keeping
  int failCount = 0;
  int checks = 0;

  // 100 MHz core clock
  always #5 sys_clk = ~sys_clk;

  // board side
  rsc_board_model i_board (.strapSet, .irqLow, .gpioOut, .gpioOe, .gpioIn,
    .switchModeStrap, .downstreamCommonClockStrap, .upstreamCommonClockStrap,
    .masterSmbusSlowStrap, .resetHoldInput, .slaveAddrPinsPresent, .slaveSmbusAddrPins,
    .eepromAddrPinsPresent, .eepromAddrPins);

  // block under test
  rsc_reset_strap_config i_dut (.sys_clk, .rst_b, .clkEn, .switchModeStrap,
    .downstreamCommonClockStrap, .upstreamCommonClockStrap, .masterSmbusSlowStrap,
    .resetHoldInput, .slaveAddrPinsPresent, .slaveSmbusAddrPins, .eepromAddrPinsPresent,
    .eepromAddrPins, .gpioIn, .gpioOut, .gpioOe, .regReq, .regRdata, .slaveSmbusAddr,
    .eepromAddr, .smbSlowMode, .smbPeriodCycles, .smbusEnable, .eepromInitEnable,
    .modeReserved, .upstreamSlotClock, .downstreamSlotClock, .expanderIrq, .coreInReset);

  // verdict and end of run
  task automatic endOfTest();
    $display("checks %0d mismatches %0d", checks, failCount);
    if (failCount == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : endOfTest

  // compare seen against expected
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failCount++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  // let edges pass, then settle
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  // one-cycle write strobe
  task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    regReq.wr <= 1'b0;
  endtask : regWrite

  // one-cycle read strobe, data taken in the following cycle
  task automatic regCheck(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    regReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    regReq.rd <= 1'b0;
    #1;
    check(what, regRdata, exp);
  endtask : regCheck

  // bounded wait for the core to leave reset
  task automatic waitRun();
    int n;
    n = 0;
    while (coreInReset !== 1'b0) begin
      tick(1);
      n++;
      if (n > 40) begin
        check("runWait", 32'h0, 32'h1);
        endOfTest();
      end
    end
  endtask : waitRun

  // reset with new straps, check the in-reset outputs, release
  task automatic bootWith(input rsc_strap_t s);
    @(posedge sys_clk);
    rst_b <= 1'b0;
    strapSet <= s;
    tick(2);
    check("inReset", coreInReset, 32'h1);
    check("oeReset", gpioOe, 32'h0);
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
  endtask : bootWith

  // main sequence
  initial begin
    rsc_strap_t s;
    // mode 1, ds common clock, slow bus, hold, no address pins
    s = '{3'h1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 4'h0, 1'b0, 4'h0};
    bootWith(s);
    tick(30);
    check("held", coreInReset, 32'h1);
    check("smbOn", smbusEnable, 32'h1);
    check("slvAddr", slaveSmbusAddr, 32'h77);
    check("eeAddr", eepromAddr, 32'h50);
    check("slow", smbSlowMode, 32'h1);
    check("period", smbPeriodCycles, 32'h3E8);
    check("eeInit", eepromInitEnable, 32'h1);
    check("dsClk", downstreamSlotClock, 32'h3);
    check("usClk", upstreamSlotClock, 32'h0);
    regCheck("haltBit", `RSC_OFF_SW_CTRL, 32'h1);
    // downstream reset pins driven low while held
    regWrite(`RSC_OFF_ALTSEL, 32'h3);
    tick(2);
    check("padHeld", {gpioOe[1:0], gpioOut[1:0]}, 32'hC);
    regWrite(`RSC_OFF_DSA_LSTS, 32'h0);
    regWrite(`RSC_OFF_US_LSTS, 32'h1000);
    regWrite(`RSC_OFF_STATUS, 32'hFFFFFFFF);
    regWrite(`RSC_OFF_SW_CTRL, 32'h0);
    waitRun();
    check("padRun", gpioOut[1:0], 32'h3);
    check("dsClkSw", downstreamSlotClock, 32'h2);
    check("usClkSw", upstreamSlotClock, 32'h1);
    check("periodKept", smbPeriodCycles, 32'h3E8);
    regCheck("dsaLsts", `RSC_OFF_DSA_LSTS, 32'h0);
    regCheck("unmapped", 8'h40, 32'h0);
    // alternate pin functions
    regWrite(`RSC_OFF_ALTSEL, 32'hFF);
    regCheck("altSel", `RSC_OFF_ALTSEL, 32'h9F);
    tick(1);
    check("padOe", gpioOe, 32'h83);
    check("padOut", gpioOut & 11'h083, 32'h3);
    for (int i = 0; i < 3; i++) begin
      regWrite(`RSC_OFF_PORTCTL, 32'h1 << i);
      irqLow <= 3'h1 << i;
      tick(3);
      check("padOut", gpioOut & 11'h083, (i == 2) ? 32'h83 : 32'h3 ^ (32'h1 << i));
      check("irq", expanderIrq, 32'h1 << i);
    end
    // a write while the clock enable is low is lost and pads hold
    @(posedge sys_clk);
    clkEn <= 1'b0;
    regWrite(`RSC_OFF_PORTCTL, 32'h0);
    tick(2);
    check("frozenPad", gpioOut & 11'h083, 32'h83);
    @(posedge sys_clk);
    clkEn <= 1'b1;
    regCheck("frozenCtl", `RSC_OFF_PORTCTL, 32'h4);
    // every mode code, address pins present, no hold, fast bus
    for (int m = 0; m < 8; m++) begin
      s = '{3'(m), 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 4'(m), 1'b1, 4'(15 - m)};
      bootWith(s);
      waitRun();
      check("eeInit", eepromInitEnable, 32'(m == 1));
      check("reserved", modeReserved, 32'(m > 1));
      check("period", smbPeriodCycles, 32'hFA);
      check("dsClk", downstreamSlotClock, 32'h0);
      check("usClk", upstreamSlotClock, 32'h1);
      check("slvAddr", slaveSmbusAddr,
        32'({1'b1, s.slvPins[3], 1'b1, s.slvPins[2:0], 1'b1}));
      check("eeAddr", eepromAddr, 32'({2'h2, s.eePins, 1'b0}));
      regCheck("altCleared", `RSC_OFF_ALTSEL, 32'h0);
      // straps moved after capture must be ignored
      @(posedge sys_clk);
      strapSet <= ~s;
      tick(3);
      check("eeInitKept", eepromInitEnable, 32'(m == 1));
      check("periodKept", smbPeriodCycles, 32'hFA);
      check("usClkKept", upstreamSlotClock, 32'h1);
    end
    endOfTest();
  end
endmodule : tb
